// ===== dcl_counter.sv
/*
 * decade counter stage: synchronous 0..9 counter gated by cascade and
 * lookahead enables, terminal count, capture latch, seven-segment
 * decoder, blanking, decimal point and ripple zero suppression node.
 * assumes every pin input is asynchronous to clk and that software
 * reaches the control and status words over ahb-lite.
 */
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/10ps

// Summary of operation
// - clear input low forces count to zero, overriding everything
// - count holds zero while clear low; counting resumes once high
// - each enabled count pulse adds one, nine wraps to zero
// - all counter bits change together on count input rising edge
// - terminal count output low at nine, high again at zero
// - cascade enable high stops counting, forces terminal count high
// - counting and terminal count need both enables low
// - lookahead enable high blocks count pulses
// - capture low: latch follows the counter
// - capture high: latch holds, counter keeps counting
// - decimal point lit only while its control is high
// - display off blanks the whole display
// - zero suppress in low and latch zero: blank, pull node low
// - suppress node is pulled-up two-way; external low blanks display
module dcl_counter
    import dcl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic count_in,
    input wire logic clear_n,
    input wire logic cascade_en,
    input wire logic lookahead_en,
    input wire logic zero_suppress_in_n,
    input wire logic zero_suppress_out_i,
    output logic zero_suppress_out_o,
    output logic zero_suppress_out_oe_n,
    output logic term_count_n,
    output logic [6:0] seg,
    output logic dp,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);

    // ************************************************
    // declarations
    // ************************************************
    logic [5:0] meta_q;
    logic [5:0] sync_q;
    logic cnt_d1_q;
    logic clr_s;
    logic casc_s;
    logic look_s;
    logic zsin_s;
    logic node_s;
    logic pulse;
    logic gate_ok;
    logic [3:0] count_q;
    logic [3:0] latch_q;
    logic tc_n_q;
    logic [2:0] ctrl_q;
    logic wr_q;
    logic [7:0] waddr_q;
    logic supp;
    logic blank;
    logic [6:0] seg_q;
    logic dp_q;
    logic blk_q;
    logic zso_oe_n_q;
    logic [31:0] rdata_q;
    logic ready_q;
    logic take;

    // digit to segment pattern, segment g in bit 6, a in bit 0
    function automatic logic [6:0] dcl_decode(input logic [3:0] v);
        logic [6:0] p;
        p = DCL_SEG_OFF;
        unique case (v)
            4'h0: p = 7'h3F;
            4'h1: p = 7'h06;
            4'h2: p = 7'h5B;
            4'h3: p = 7'h4F;
            4'h4: p = 7'h66;
            4'h5: p = 7'h6D;
            4'h6: p = 7'h7D;
            4'h7: p = 7'h07;
            4'h8: p = 7'h7F;
            4'h9: p = 7'h6F;
            default: p = DCL_SEG_OFF;
        endcase
        return p;
    endfunction

    // ************************************************
    // pin synchronisers
    // ************************************************
    // first rank is read only by the second rank
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 6'h3F;
            sync_q <= 6'h3F;
        end else begin
            meta_q <= {zero_suppress_out_i, zero_suppress_in_n,
                       lookahead_en, cascade_en, clear_n, count_in};
            sync_q <= meta_q;
        end
    end

    assign clr_s = sync_q[1];
    assign casc_s = sync_q[2];
    assign look_s = sync_q[3];
    assign zsin_s = sync_q[4];
    assign node_s = sync_q[5];

    // rising edge of the synced count input
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_d1_q <= 1'b1;
        end else begin
            cnt_d1_q <= sync_q[0];
        end
    end

    // enables sampled at the edge; stable while count low
    assign gate_ok = !casc_s && !look_s;
    assign pulse = sync_q[0] && !cnt_d1_q && gate_ok;

    // ************************************************
    // decade counter
    // ************************************************
    // clear wins over any pulse in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= DCL_ZERO;
        end else if (!clr_s) begin
            count_q <= DCL_ZERO;
        end else if (pulse) begin
            if (count_q == DCL_MAX) begin
                count_q <= DCL_ZERO;
            end else begin
                count_q <= count_q + DCL_ONE;
            end
        end
    end

    // terminal count, forced high unless both enables low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tc_n_q <= 1'b1;
        end else begin
            tc_n_q <= !(gate_ok && count_q == DCL_MAX);
        end
    end

    // ************************************************
    // capture latch
    // ************************************************
    // one clock behind the counter when transparent
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latch_q <= DCL_ZERO;
        end else if (!ctrl_q[DCL_CTRL_HOLD]) begin
            latch_q <= count_q;
        end
    end

    // ************************************************
    // display and suppression
    // ************************************************
    assign supp = !zsin_s && latch_q == DCL_ZERO;
    // node low from outside blanks; own drive loops back harmlessly
    assign blank = ctrl_q[DCL_CTRL_OFF] || supp || !node_s;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seg_q <= DCL_SEG_OFF;
            dp_q <= 1'b0;
            blk_q <= 1'b1;
            zso_oe_n_q <= 1'b1;
        end else begin
            seg_q <= blank ? DCL_SEG_OFF : dcl_decode(latch_q);
            dp_q <= ctrl_q[DCL_CTRL_DP] && !ctrl_q[DCL_CTRL_OFF];
            blk_q <= blank;
            zso_oe_n_q <= !supp;
        end
    end

    // ************************************************
    // ahb-lite slave
    // ************************************************
    // zero wait states: the answer is ready in every data phase
    assign take = hsel && htrans[1] && hready;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= 1'b0;
            waddr_q <= 8'h00;
            ready_q <= 1'b1;
        end else begin
            wr_q <= take && hwrite;
            waddr_q <= haddr[7:0];
            ready_q <= 1'b1;
        end
    end

    // write lands at the end of the data phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= DCL_CTRL_RST;
        end else if (wr_q && waddr_q == DCL_CTRL_ADDR) begin
            ctrl_q <= hwdata[2:0];
        end
    end

    // read data built in the address phase; unmapped reads zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            rdata_q <= 32'h0000_0000;
            if (haddr[7:0] == DCL_CTRL_ADDR) begin
                rdata_q[2:0] <= ctrl_q;
            end else if (haddr[7:0] == DCL_STAT_ADDR) begin
                rdata_q[DCL_STAT_CNT +: 4] <= count_q;
                rdata_q[DCL_STAT_LAT +: 4] <= latch_q;
                rdata_q[DCL_STAT_TC] <= tc_n_q;
                rdata_q[DCL_STAT_BLK] <= blk_q;
            end
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign term_count_n = tc_n_q;
    assign seg = seg_q;
    assign dp = dp_q;
    assign zero_suppress_out_o = 1'b0;
    assign zero_suppress_out_oe_n = zso_oe_n_q;
    assign hreadyout = ready_q;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    clear_zero_a: assert property (!clr_s |=> count_q == DCL_ZERO)
        else $error("count not zero after clear");

    clear_hold_a: assert property (!clr_s [*3] |-> count_q == DCL_ZERO)
        else $error("count moved while clear low");

    count_wrap_a: assert property (clr_s && pulse && count_q == DCL_MAX
        |=> count_q == DCL_ZERO)
        else $error("nine did not wrap to zero");

    count_step_a: assert property (clr_s && pulse && count_q < DCL_MAX
        |=> count_q == $past(count_q) + DCL_ONE)
        else $error("count did not advance by one");

    edge_only_a: assert property (clr_s && !(sync_q[0] && !cnt_d1_q)
        |=> $stable(count_q))
        else $error("count moved without an edge");

    tc_low_a: assert property (gate_ok && count_q == DCL_MAX
        |=> !term_count_n)
        else $error("terminal count not low at nine");

    tc_forced_a: assert property (casc_s |=> term_count_n)
        else $error("terminal count not forced high");

    gate_block_a: assert property (clr_s && (casc_s || look_s)
        |=> $stable(count_q))
        else $error("count moved while gated off");

    latch_follow_a: assert property (!ctrl_q[DCL_CTRL_HOLD]
        |=> latch_q == $past(count_q))
        else $error("latch not following counter");

    latch_hold_a: assert property (ctrl_q[DCL_CTRL_HOLD]
        |=> $stable(latch_q))
        else $error("latch changed while held");

    dp_ctrl_a: assert property (##1 dp == $past(ctrl_q[DCL_CTRL_DP]
        && !ctrl_q[DCL_CTRL_OFF]))
        else $error("decimal point wrong");

    off_blank_a: assert property (ctrl_q[DCL_CTRL_OFF]
        |=> seg == DCL_SEG_OFF && !dp)
        else $error("display not blanked when off");

    zero_supp_a: assert property (!zsin_s && latch_q == DCL_ZERO
        |=> !zero_suppress_out_oe_n && seg == DCL_SEG_OFF)
        else $error("zero not suppressed");

    node_blank_a: assert property (!node_s |=> seg == DCL_SEG_OFF)
        else $error("external node low did not blank");

    decode_show_a: assert property (!blank
        |=> seg == dcl_decode($past(latch_q)))
        else $error("segment pattern wrong");

    count_range_a: assert property (count_q <= DCL_MAX)
        else $error("count left the decade");

    tc_high_a: assert property (gate_ok && count_q != DCL_MAX |=> term_count_n)
        else $error("terminal count low away from nine");

    look_tc_a: assert property (look_s |=> term_count_n)
        else $error("terminal count not high under lookahead");

    dp_only_a: assert property (!ctrl_q[DCL_CTRL_DP] |=> !dp)
        else $error("decimal point lit without control");

    supp_off_a: assert property (zsin_s |=> zero_suppress_out_oe_n)
        else $error("suppress node driven without cause");

    blank_wins_a: assert property (blank |=> seg == DCL_SEG_OFF)
        else $error("segments lit while blanked");

endmodule

// ===== dcl_pkg.sv
/*
 * constants for the decade counter stage with latch and display drive:
 * register map, field positions, reset values and digit limits.
 * assumes a 32-bit ahb-lite bus and one 200 MHz system clock.
 */
package dcl_pkg;

    // ************************************************
    // register map
    // ************************************************
    localparam logic [7:0] DCL_CTRL_ADDR = 8'h00;
    localparam logic [7:0] DCL_STAT_ADDR = 8'h04;
    localparam logic [2:0] DCL_CTRL_RST = 3'h0;

    // ************************************************
    // control field positions
    // ************************************************
    localparam int DCL_CTRL_HOLD = 0;
    localparam int DCL_CTRL_DP = 1;
    localparam int DCL_CTRL_OFF = 2;

    // ************************************************
    // status field positions
    // ************************************************
    localparam int DCL_STAT_CNT = 0;
    localparam int DCL_STAT_LAT = 4;
    localparam int DCL_STAT_TC = 8;
    localparam int DCL_STAT_BLK = 9;

    // ************************************************
    // digit limits and pattern width
    // ************************************************
    localparam logic [3:0] DCL_ZERO = 4'h0;
    localparam logic [3:0] DCL_MAX = 4'h9;
    localparam logic [3:0] DCL_ONE = 4'h1;
    localparam int DCL_SEG_W = 7;
    localparam logic [6:0] DCL_SEG_OFF = 7'h00;

endpackage

// ===== dcl_neighbour.sv
/*
 * neighbour stage and gating logic model for the decade counter stage.
 * assumes its tasks are called just after a rising clk edge.
 */
`timescale 1ns/10ps

module dcl_neighbour (
    input wire logic clk,
    input wire logic node_oe_n,
    input wire logic node_o,
    input wire logic ext_low,
    output logic count_in,
    output logic cascade_en,
    output logic lookahead_en,
    output logic node
);
    // ************************************************
    // suppress node and count line
    // ************************************************
    // pulled-up wire: any enabled low driver wins
    assign node = ~((~node_oe_n & ~node_o) | ext_low);

    // count line idles high so the enables may move between pulses
    initial begin
        count_in = 1'b1;
        cascade_en = 1'b0;
        lookahead_en = 1'b0;
    end

    // enables change only while the count line is high
    task automatic set_en(input logic ce, input logic la);
        cascade_en <= ce;
        lookahead_en <= la;
        repeat (4) @(posedge clk);
    endtask

    // low then high; the rising edge counts, then time for seg to settle
    task automatic pulse();
        count_in <= 1'b0;
        repeat (3) @(posedge clk);
        count_in <= 1'b1;
        repeat (7) @(posedge clk);
    endtask
endmodule

// ===== decade_counter_latch_display_test.sv
/*
 * self-checking bench for the decade counter stage: bus tasks, pin checks.
 * assumes the neighbour model drives the count line and enables.
 */
`timescale 1ns/10ps

module decade_counter_latch_display_test;
    import dcl_pkg::*;
    // ************************************************
    // signals
    // ************************************************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic clear_n = 1'b1;
    logic zs_in_n = 1'b1;
    logic ext_low = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] r;
    logic hreadyout, hresp, count_in, ce, la, node, node_o, node_oe_n, tc_n, dp;
    logic [6:0] seg;
    logic [6:0] pat [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // units under test
    dcl_counter u_dut (.clk(clk), .rst(rst), .count_in(count_in), .clear_n(clear_n),
        .cascade_en(ce), .lookahead_en(la), .zero_suppress_in_n(zs_in_n),
        .zero_suppress_out_i(node), .zero_suppress_out_o(node_o),
        .zero_suppress_out_oe_n(node_oe_n), .term_count_n(tc_n), .seg(seg), .dp(dp),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
    dcl_neighbour u_nb (.clk(clk), .node_oe_n(node_oe_n), .node_o(node_o), .ext_low(ext_low),
        .count_in(count_in), .cascade_en(ce), .lookahead_en(la), .node(node));

    // ************************************************
    // helpers
    // ************************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard, well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one single transfer; read data taken at the edge ending the data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask

    function automatic logic [31:0] stat(input logic [3:0] c, input logic [3:0] l, input logic t, input logic b);
        return {22'h0, b, t, l, c};
    endfunction

    task automatic pins(input logic [6:0] s, input logic d, input logic oe);
        chk("seg", {25'h0, seg}, {25'h0, s});
        chk("dp", {31'h0, dp}, {31'h0, d});
        chk("oe_n", {31'h0, node_oe_n}, {31'h0, oe});
    endtask

    // ************************************************
    // tests
    // ************************************************
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        bus(0, DCL_CTRL_ADDR, 0);
        chk("ctrl", r, 32'h0);
        bus(0, DCL_STAT_ADDR, 0);
        chk("stat", r, stat(0, 0, 1, 0));
        pins(pat[0], 0, 1);
        $display("test reset done");
        // count up to nine
        for (int i = 1; i <= 9; i++) begin
            u_nb.pulse();
            bus(0, DCL_STAT_ADDR, 0);
            chk("stat", r, stat(4'(i), 4'(i), i != 9, 0));
            chk("seg", {25'h0, seg}, {25'h0, pat[i]});
            chk("tc_n", {31'h0, tc_n}, {31'h0, i != 9});
        end
        u_nb.set_en(1, 0);
        bus(0, DCL_STAT_ADDR, 0);
        chk("stat", r, stat(9, 9, 1, 0));
        chk("tc_n", {31'h0, tc_n}, 32'h1);
        u_nb.pulse();
        bus(0, DCL_STAT_ADDR, 0);
        chk("stat", r, stat(9, 9, 1, 0));
        u_nb.set_en(0, 1);
        u_nb.pulse();
        bus(0, DCL_STAT_ADDR, 0);
        chk("count", {24'h0, r[7:0]}, 32'h99);
        u_nb.set_en(0, 0);
        bus(0, DCL_STAT_ADDR, 0);
        chk("stat", r, stat(9, 9, 0, 0));
        chk("tc_n", {31'h0, tc_n}, 32'h0);
        u_nb.pulse();
        bus(0, DCL_STAT_ADDR, 0);
        chk("stat", r, stat(0, 0, 1, 0));
        $display("test count done");
        // capture holds while counting goes on
        bus(1, DCL_CTRL_ADDR, 32'h1);
        u_nb.pulse();
        u_nb.pulse();
        bus(0, DCL_STAT_ADDR, 0);
        chk("stat", r, stat(2, 0, 1, 0));
        bus(1, DCL_CTRL_ADDR, 32'h0);
        repeat (3) @(posedge clk);
        bus(0, DCL_STAT_ADDR, 0);
        chk("stat", r, stat(2, 2, 1, 0));
        $display("test latch done");
        // decimal point and display off
        bus(1, DCL_CTRL_ADDR, 32'h2);
        repeat (3) @(posedge clk);
        pins(pat[2], 1, 1);
        bus(1, DCL_CTRL_ADDR, 32'h6);
        repeat (3) @(posedge clk);
        pins(DCL_SEG_OFF, 0, 1);
        bus(0, DCL_STAT_ADDR, 0);
        chk("stat", r, stat(2, 2, 1, 1));
        bus(1, DCL_CTRL_ADDR, 32'h0);
        $display("test display done");
        // zero suppression and clear
        zs_in_n <= 1'b0;
        repeat (4) @(posedge clk);
        pins(pat[2], 0, 1);
        clear_n <= 1'b0;
        repeat (4) @(posedge clk);
        u_nb.pulse();
        bus(0, DCL_STAT_ADDR, 0);
        chk("stat", r, stat(0, 0, 1, 1));
        pins(DCL_SEG_OFF, 0, 0);
        chk("node", {31'h0, node}, 32'h0);
        clear_n <= 1'b1;
        zs_in_n <= 1'b1;
        repeat (4) @(posedge clk);
        u_nb.pulse();
        pins(pat[1], 0, 1);
        ext_low <= 1'b1;
        repeat (4) @(posedge clk);
        pins(DCL_SEG_OFF, 0, 1);
        ext_low <= 1'b0;
        $display("test suppress done");
        // unmapped read and read-only status
        bus(0, 8'h08, 0);
        chk("unmapped", r, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
        bus(1, DCL_STAT_ADDR, 32'hFF);
        bus(0, DCL_STAT_ADDR, 0);
        chk("stat", r, stat(1, 1, 1, 0));
        $display("test bus done");
        complete_run();
    end
endmodule
